//--- design/nst_consts.vh
// Constants for the numeric sensor threshold state block.
`ifndef NST_CONSTS_VH
`define NST_CONSTS_VH
// Register byte offsets.
`define NST_OFS_CTRL 6'h00
`define NST_OFS_PERIOD 6'h04
`define NST_OFS_HYST 6'h08
`define NST_OFS_LIM_LF 6'h0c
`define NST_OFS_LIM_LC 6'h10
`define NST_OFS_LIM_LW 6'h14
`define NST_OFS_LIM_UW 6'h18
`define NST_OFS_LIM_UC 6'h1c
`define NST_OFS_LIM_UF 6'h20
`define NST_OFS_HANDLE 6'h24
`define NST_OFS_READ_REQ 6'h28
`define NST_OFS_SET_OP 6'h2c
`define NST_OFS_INIT_REQ 6'h30
`define NST_OFS_RESTORE 6'h34
`define NST_OFS_STATUS 6'h38
`define NST_OFS_READING 6'h3c
// Control register fields and reset value.
`define NST_CTRL_MANUAL_BIT 0
`define NST_CTRL_EVSUP_BIT 1
`define NST_CTRL_LIMEN_LSB 8
`define NST_CTRL_RESET 32'h00003f02
// Zone codes.
`define NST_ZONE_NORMAL 3'h0
`define NST_ZONE_LOW_WARN 3'h1
`define NST_ZONE_LOW_CRIT 3'h2
`define NST_ZONE_LOW_FATAL 3'h3
`define NST_ZONE_HIGH_WARN 3'h4
`define NST_ZONE_HIGH_CRIT 3'h5
`define NST_ZONE_HIGH_FATAL 3'h6
// Operating condition codes (initialising is reported only).
`define NST_OP_ENABLED 2'h0
`define NST_OP_DISABLED 2'h1
`define NST_OP_UNAVAILABLE 2'h2
`define NST_OP_INITIALISING 2'h3
// Event report control codes.
`define NST_EV_KEEP_CURRENT 3'h0
`define NST_EV_REPORTING_OFF 3'h1
`define NST_EV_REPORTING_ALL_ON 3'h2
`define NST_EV_REPORTING_OPERATIONAL_ONLY 3'h3
`define NST_EV_REPORTING_ZONE_ONLY 3'h4
// Completion codes.
`define NST_CC_SUCCESS 8'h00
`define NST_CC_INVALID_DATA 8'h02
`define NST_CC_INVALID_HANDLE 8'h80
// Reserved handles.
`define NST_HANDLE_RSVD_LO 16'h0000
`define NST_HANDLE_RSVD_HI 16'hffff
// Sampling period default, in clock cycles.
`define NST_PERIOD_RESET 32'h00000100
`endif

//--- design/nst_sensor.v
// Numeric sensor threshold zone, hysteresis event zone and command logic with an AHB-Lite register slave.
`include "nst_consts.vh"
`default_nettype none

module nst_sensor #(
    parameter RW = 16,
    parameter [15:0] OWN_HANDLE = 16'h0001, // Arbitrary value.
    parameter [31:0] PERIOD_DEF = `NST_PERIOD_RESET,
    parameter [RW-1:0] HYST_DEF = 1,
    parameter [6*RW-1:0] LIMITS_DEF = 0
) (
    // Clock and reset.
    input wire clk_i,
    input wire arst_n_i,
    // AHB-Lite slave.
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output wire [31:0] hrdata_o,
    output wire hreadyout_o,
    output wire hresp_o,
    // Sensor pins.
    input wire [RW-1:0] reading_i,
    input wire trigger_i,
    // Event messages.
    output wire evt_valid_o,
    output wire evt_kind_o,
    output wire [2:0] evt_zone_o,
    output wire [1:0] evt_op_o
);

////////////////////////////////////////////////////////////////////////////////
// Severity and zone helpers.

// Severity rank of a zone, upper and lower of one level equal.
function [1:0] sev;
    input [2:0] z;
    begin
        case (z)
            `NST_ZONE_LOW_WARN, `NST_ZONE_HIGH_WARN: sev = 2'd1;
            `NST_ZONE_LOW_CRIT, `NST_ZONE_HIGH_CRIT: sev = 2'd2;
            `NST_ZONE_LOW_FATAL, `NST_ZONE_HIGH_FATAL: sev = 2'd3;
            default: sev = 2'd0;
        endcase
    end
endfunction

// Zone of a reading; limits bordering the held zone's side are shifted by off.
function [2:0] zone_of;
    input signed [RW:0] r;
    input [6*RW-1:0] lim;
    input [5:0] en;
    input [2:0] held;
    input signed [RW:0] off;
    reg signed [RW:0] t;
    reg [1:0] hs;
    reg up;
    integer k;
    begin
        zone_of = `NST_ZONE_NORMAL;
        hs = sev(held);
        up = (held >= `NST_ZONE_HIGH_WARN);
        // Lower limits, least severe first so the most severe wins.
        for (k = 2; k >= 0; k = k - 1) begin
            t = {lim[k*RW+RW-1], lim[k*RW +: RW]};
            if (!up && hs >= (3 - k)) begin
                t = t + off;
            end
            if (en[k] && r <= t) begin
                zone_of = 3'd3 - k[2:0];
            end
        end
        // Upper limits override lower ones when both match.
        for (k = 3; k <= 5; k = k + 1) begin
            t = {lim[k*RW+RW-1], lim[k*RW +: RW]};
            if (up && hs >= (k - 2)) begin
                t = t - off;
            end
            if (en[k] && r >= t) begin
                zone_of = k[2:0] + 3'd1;
            end
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers.

reg [RW-1:0] rd_s1_r;
reg [RW-1:0] rd_s2_r;
reg trg_s1_r;
reg trg_s2_r;
reg trg_d_r;

// Two flip-flops on the reading and trigger pins; edge detect after the second.
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        rd_s1_r <= {RW{1'b0}};
        rd_s2_r <= {RW{1'b0}};
        trg_s1_r <= 1'b0;
        trg_s2_r <= 1'b0;
        trg_d_r <= 1'b0;
    end else begin
        rd_s1_r <= reading_i;
        rd_s2_r <= rd_s1_r;
        trg_s1_r <= trigger_i;
        trg_s2_r <= trg_s1_r;
        trg_d_r <= trg_s2_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register bus.

reg [31:0] ctrl_r;
reg [31:0] period_r;
reg [RW-1:0] hyst_r;
reg [6*RW-1:0] lim_r;
reg [15:0] handle_r;
reg [31:0] hrdata_r;
reg [5:0] waddr_r;
reg wact_r;
reg [2:0] zone_r;
reg [2:0] evz_r;
reg [1:0] op_r;
reg [2:0] evctl_r;
reg init_r;
reg [7:0] cc_r;
reg [RW-1:0] snap_r;

wire addr_ok = hsel_i && hready_i && htrans_i[1];
wire [5:0] raddr = haddr_i[5:0];
wire [31:0] status_w = {8'h00, cc_r, 1'b0, init_r, (init_r ? `NST_OP_INITIALISING : op_r),
    1'b0, evctl_r, 1'b0, evz_r, 1'b0, zone_r};

// Write strobes from the latched data phase.
wire wr_ctrl = wact_r && waddr_r == `NST_OFS_CTRL;
wire wr_read = wact_r && waddr_r == `NST_OFS_READ_REQ;
wire wr_setop = wact_r && waddr_r == `NST_OFS_SET_OP;
wire wr_init = wact_r && waddr_r == `NST_OFS_INIT_REQ;
wire wr_rest = wact_r && waddr_r == `NST_OFS_RESTORE;
wire handle_ok = handle_r == OWN_HANDLE && handle_r != `NST_HANDLE_RSVD_LO
    && handle_r != `NST_HANDLE_RSVD_HI;

// Zero-wait slave: read data is registered at the address phase, writes land in the data phase.
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        hrdata_r <= 32'h00000000;
        waddr_r <= 6'h00;
        wact_r <= 1'b0;
    end else begin
        wact_r <= addr_ok && hwrite_i && haddr_i[31:6] == 26'h0000000;
        waddr_r <= raddr;
        hrdata_r <= 32'h00000000;
        if (addr_ok && !hwrite_i && haddr_i[31:6] == 26'h0000000) begin
            case (raddr)
                `NST_OFS_CTRL: hrdata_r <= ctrl_r;
                `NST_OFS_PERIOD: hrdata_r <= period_r;
                `NST_OFS_HYST: hrdata_r <= {{(32-RW){1'b0}}, hyst_r};
                `NST_OFS_LIM_LF: hrdata_r <= {{(32-RW){1'b0}}, lim_r[0*RW +: RW]};
                `NST_OFS_LIM_LC: hrdata_r <= {{(32-RW){1'b0}}, lim_r[1*RW +: RW]};
                `NST_OFS_LIM_LW: hrdata_r <= {{(32-RW){1'b0}}, lim_r[2*RW +: RW]};
                `NST_OFS_LIM_UW: hrdata_r <= {{(32-RW){1'b0}}, lim_r[3*RW +: RW]};
                `NST_OFS_LIM_UC: hrdata_r <= {{(32-RW){1'b0}}, lim_r[4*RW +: RW]};
                `NST_OFS_LIM_UF: hrdata_r <= {{(32-RW){1'b0}}, lim_r[5*RW +: RW]};
                `NST_OFS_HANDLE: hrdata_r <= {16'h0000, handle_r};
                `NST_OFS_STATUS: hrdata_r <= status_w;
                `NST_OFS_READING: hrdata_r <= {{(32-RW){1'b0}}, snap_r};
                default: hrdata_r <= 32'h00000000;
            endcase
        end
    end
end

assign hrdata_o = hrdata_r;
assign hreadyout_o = 1'b1;
assign hresp_o = 1'b0;

// Configuration registers; restore brings limits and hysteresis back to defaults.
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        ctrl_r <= `NST_CTRL_RESET;
        period_r <= PERIOD_DEF;
        hyst_r <= HYST_DEF;
        lim_r <= LIMITS_DEF;
        handle_r <= 16'h0000;
    end else if (wr_rest) begin
        hyst_r <= HYST_DEF;
        lim_r <= LIMITS_DEF;
    end else if (wact_r) begin
        case (waddr_r)
            `NST_OFS_CTRL: ctrl_r <= hwdata_i & 32'h00003f03;
            `NST_OFS_PERIOD: period_r <= hwdata_i;
            `NST_OFS_HYST: hyst_r <= hwdata_i[RW-1:0];
            `NST_OFS_LIM_LF: lim_r[0*RW +: RW] <= hwdata_i[RW-1:0];
            `NST_OFS_LIM_LC: lim_r[1*RW +: RW] <= hwdata_i[RW-1:0];
            `NST_OFS_LIM_LW: lim_r[2*RW +: RW] <= hwdata_i[RW-1:0];
            `NST_OFS_LIM_UW: lim_r[3*RW +: RW] <= hwdata_i[RW-1:0];
            `NST_OFS_LIM_UC: lim_r[4*RW +: RW] <= hwdata_i[RW-1:0];
            `NST_OFS_LIM_UF: lim_r[5*RW +: RW] <= hwdata_i[RW-1:0];
            `NST_OFS_HANDLE: handle_r <= hwdata_i[15:0];
            default: handle_r <= handle_r;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Sampling schedule.

reg [31:0] tick_cnt_r;
reg pend_r;
wire tick = (tick_cnt_r >= period_r - 32'd1);
wire trig = trg_s2_r && !trg_d_r;
wire cmd_busy = wr_read || wr_setop || wr_init || wr_ctrl;
wire do_update = pend_r && !cmd_busy && op_r == `NST_OP_ENABLED;

// A pending sample waits out command writes so that a command and an update never collide.
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        tick_cnt_r <= 32'h00000000;
        pend_r <= 1'b0;
    end else begin
        tick_cnt_r <= tick ? 32'h00000000 : tick_cnt_r + 32'd1;
        if (tick || trig) begin
            pend_r <= 1'b1;
        end else if (do_update) begin
            pend_r <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Zone evaluation.

wire signed [RW:0] rd_x = {rd_s2_r[RW-1], rd_s2_r};
wire signed [RW:0] hoff = (hyst_r == {RW{1'b0}}) ? {(RW+1){1'b0}} : {1'b0, hyst_r} - {{RW{1'b0}}, 1'b1};
wire [2:0] unf_w = zone_of(rd_x, lim_r, ctrl_r[`NST_CTRL_LIMEN_LSB +: 6], `NST_ZONE_NORMAL,
    {(RW+1){1'b0}});
wire [2:0] hyz_w = zone_of(rd_x, lim_r, ctrl_r[`NST_CTRL_LIMEN_LSB +: 6], evz_r, hoff);
wire manual = ctrl_r[`NST_CTRL_MANUAL_BIT];
wire ev_sup = ctrl_r[`NST_CTRL_EVSUP_BIT];
wire zone_rep = ev_sup && (evctl_r == `NST_EV_REPORTING_ALL_ON || evctl_r == `NST_EV_REPORTING_ZONE_ONLY);
wire op_rep = ev_sup && (evctl_r == `NST_EV_REPORTING_ALL_ON
    || evctl_r == `NST_EV_REPORTING_OPERATIONAL_ONLY);
reg [2:0] evz_nxt;

// Next event zone under auto or manual re-arm.
always @* begin
    if (init_r) begin
        evz_nxt = unf_w;
    end else if (!manual) begin
        evz_nxt = hyz_w;
    end else if (sev(hyz_w) >= sev(evz_r)) begin
        evz_nxt = hyz_w;
    end else begin
        evz_nxt = evz_r;
    end
end

// Set-operation request decode.
wire [1:0] req_op = hwdata_i[1:0];
wire [2:0] req_ev = hwdata_i[4:2];
wire op_ok = req_op != `NST_OP_INITIALISING;
wire ev_ok = req_ev <= `NST_EV_REPORTING_ZONE_ONLY && (ev_sup || req_ev == `NST_EV_KEEP_CURRENT);

reg evt_valid_r;
reg evt_kind_r;
reg [2:0] evt_zone_r;
reg [1:0] evt_op_r;

////////////////////////////////////////////////////////////////////////////////
// Sensor state, commands and event messages.

always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        zone_r <= `NST_ZONE_NORMAL;
        evz_r <= `NST_ZONE_NORMAL;
        op_r <= `NST_OP_ENABLED;
        evctl_r <= `NST_EV_REPORTING_OFF;
        init_r <= 1'b1;
        cc_r <= `NST_CC_SUCCESS;
        snap_r <= {RW{1'b0}};
        evt_valid_r <= 1'b0;
        evt_kind_r <= 1'b0;
        evt_zone_r <= `NST_ZONE_NORMAL;
        evt_op_r <= `NST_OP_ENABLED;
    end else begin
        evt_valid_r <= 1'b0;
        if (wr_read) begin
            // Read request: snapshot values, optionally re-arm.
            if (!handle_ok) begin
                cc_r <= `NST_CC_INVALID_HANDLE;
            end else begin
                cc_r <= `NST_CC_SUCCESS;
                snap_r <= rd_s2_r;
                if (hwdata_i[0]) begin
                    init_r <= 1'b1;
                end
            end
        end else if (wr_init) begin
            if (!handle_ok) begin
                cc_r <= `NST_CC_INVALID_HANDLE;
            end else begin
                cc_r <= `NST_CC_SUCCESS;
                init_r <= 1'b1;
            end
        end else if (wr_setop) begin
            // Only the sensor's own state and reporting change here.
            if (!handle_ok) begin
                cc_r <= `NST_CC_INVALID_HANDLE;
            end else if (!op_ok || !ev_ok) begin
                cc_r <= `NST_CC_INVALID_DATA;
            end else begin
                cc_r <= `NST_CC_SUCCESS;
                op_r <= req_op;
                if (req_op == `NST_OP_ENABLED && op_r != `NST_OP_ENABLED) begin
                    init_r <= 1'b1;
                end
                if (req_ev != `NST_EV_KEEP_CURRENT) begin
                    evctl_r <= req_ev;
                end
                if (req_op != op_r && op_rep) begin
                    evt_valid_r <= 1'b1;
                    evt_kind_r <= 1'b1;
                    evt_op_r <= req_op;
                    evt_zone_r <= evz_r;
                end
            end
        end else if (do_update) begin
            zone_r <= unf_w;
            evz_r <= evz_nxt;
            init_r <= 1'b0;
            if (zone_rep && (init_r || evz_nxt != evz_r)) begin
                evt_valid_r <= 1'b1;
                evt_kind_r <= 1'b0;
                evt_zone_r <= evz_nxt;
                evt_op_r <= op_r;
            end
        end
    end
end

assign evt_valid_o = evt_valid_r;
assign evt_kind_o = evt_kind_r;
assign evt_zone_o = evt_zone_r;
assign evt_op_o = evt_op_r;

endmodule // nst_sensor

`default_nettype wire

//--- tb/nst_sensor_asserts.sv
// Checker of bus and event port timing for the sensor block.
`default_nettype none
module nst_sensor_asserts (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Bus.
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Events.
    input wire logic evt_valid_o,
    input wire logic evt_kind_o,
    input wire logic [2:0] evt_zone_o,
    input wire logic [1:0] evt_op_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    logic rd_r;
    logic hi_r;
    logic [2:0] op_r;
    wire logic ap = hsel_i && hready_i && htrans_i[1];
    // Marks the read data phase of the last cycle (and whether its address was high) and operation command write address phases seen in each of the last three cycles.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_r <= 1'b0;
            hi_r <= 1'b0;
            op_r <= 3'h0;
        end else begin
            rd_r <= ap && !hwrite_i;
            hi_r <= ap && !hwrite_i && haddr_i[31:6] != 26'h0;
            op_r <= {op_r[1:0], ap && hwrite_i && haddr_i == 32'h0000002c};
        end
    end
    AST_HREADY: assert property (hreadyout_o == 1'b1) else $error("hreadyout low");
    AST_HRESP: assert property (hresp_o == 1'b0) else $error("hresp not okay");
    AST_RD_IDLE: assert property (!rd_r |-> hrdata_o == 32'h0) else $error("hrdata outside read");
    AST_RD_HIGH: assert property (hi_r |-> hrdata_o == 32'h0) else $error("high address read nonzero");
    AST_EVT_HOLD: assert property (!evt_valid_o |-> $stable({evt_kind_o, evt_zone_o, evt_op_o}))
        else $error("event data moved");
    AST_ZONE_CODE: assert property (evt_valid_o && !evt_kind_o |-> evt_zone_o != 3'h7)
        else $error("bad zone code");
    AST_OP_CODE: assert property (evt_valid_o && evt_kind_o |-> evt_op_o != 2'h3)
        else $error("bad op code");
    AST_OP_CAUSE: assert property (evt_valid_o && evt_kind_o |-> op_r != 3'h0)
        else $error("op event without command");
endmodule // nst_sensor_asserts
bind nst_sensor nst_sensor_asserts i_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .evt_valid_o(evt_valid_o),
    .evt_kind_o(evt_kind_o), .evt_zone_o(evt_zone_o), .evt_op_o(evt_op_o));
`default_nettype wire

//--- tb/nst_host.sv
// Management requester model running single word AHB-Lite transfers.
`default_nettype none
module nst_host (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Bench request.
    input wire logic req_i,
    input wire logic wr_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    output logic done_o,
    output logic [31:0] rdata_o,
    // Bus.
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [31:0] hwdata_o,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i
);
    logic [1:0] st_r;
    // Each phase is held until hready is seen; released write data is inverted.
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= 2'h0;
            htrans_o <= 2'h0;
            haddr_o <= 32'h0;
            hwrite_o <= 1'b0;
            hwdata_o <= 32'h0;
            rdata_o <= 32'h0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (st_r)
                2'h0: if (req_i) begin
                    haddr_o <= addr_i;
                    hwrite_o <= wr_i;
                    htrans_o <= 2'h2;
                    st_r <= 2'h1;
                end
                2'h1: if (hready_i) begin
                    htrans_o <= 2'h0;
                    hwdata_o <= wdata_i;
                    st_r <= 2'h2;
                end
                default: if (hready_i) begin
                    rdata_o <= hrdata_i;
                    hwdata_o <= ~wdata_i;
                    done_o <= 1'b1;
                    st_r <= 2'h0;
                end
            endcase
        end
    end
endmodule // nst_host
`default_nettype wire

//--- tb/nst_sensor_bench.sv
// Self-checking bench for the numeric sensor threshold block.
`include "nst_consts.vh"
`default_nettype none
module nst_sensor_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic req = 1'b0;
    logic wr = 1'b0;
    logic [31:0] ad = 32'h0;
    logic [31:0] wd = 32'h0;
    logic [15:0] rv = 16'h0;
    logic trg = 1'b0;
    logic done, hwrite, hready, hresp, ev_v, ev_k;
    logic [31:0] rdata, haddr, hwdata, hrdata, s, q;
    logic [1:0] htrans, ev_o;
    logic [2:0] ev_z;
    int fails = 0;
    int checks = 0;
    int evn = 0;
    int n;
    // Clock at 40 MHz.
    always #12.5 clk_i = ~clk_i;
    // Counts event pulses.
    always @(posedge clk_i) if (ev_v === 1'b1) evn <= evn + 1;
    nst_host i_host (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req), .wr_i(wr), .addr_i(ad), .wdata_i(wd),
        .done_o(done), .rdata_o(rdata), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
        .hwdata_o(hwdata), .hready_i(hready), .hrdata_i(hrdata));
    nst_sensor i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .reading_i(rv), .trigger_i(trg), .evt_valid_o(ev_v),
        .evt_kind_o(ev_k), .evt_zone_o(ev_z), .evt_op_o(ev_o));
    task automatic finish_test;
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        k = 0;
        req <= 1'b1;
        wr <= w;
        ad <= a;
        wd <= d;
        @(posedge clk_i);
        req <= 1'b0;
        do begin
            @(posedge clk_i);
            k++;
        end while (done !== 1'b1 && k < 50);
        s = rdata;
        // A transfer that never completes ends the run as a failure.
        if (done !== 1'b1) begin
            fails++;
            finish_test();
        end
    endtask
    task automatic w32(input logic [5:0] o, input logic [31:0] d);
        bus(1'b1, {26'h0, o}, d);
    endtask
    task automatic r32(input logic [5:0] o);
        bus(1'b0, {26'h0, o}, 32'h0);
    endtask
    // Presents a reading, then triggers one sample.
    task automatic smp(input logic [15:0] v);
        rv <= v;
        repeat (4) @(posedge clk_i);
        trg <= 1'b1;
        repeat (3) @(posedge clk_i);
        trg <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic zs(input logic [15:0] v, input logic [2:0] u, input logic [2:0] e);
        smp(v);
        r32(`NST_OFS_STATUS);
        chk({25'h0, s[6:0]}, {25'h0, 1'b0, e, 1'b0, u});
    endtask
    task automatic t_reset;
        r32(`NST_OFS_CTRL);
        chk(s, `NST_CTRL_RESET);
        r32(`NST_OFS_STATUS);
        chk(s, 32'h00007100);
        bus(1'b0, 32'h00000040, 32'h0);
        chk(s, 32'h0);
        w32(`NST_OFS_HANDLE, 32'h1);
        w32(`NST_OFS_PERIOD, 32'h00ffffff);
        w32(`NST_OFS_LIM_LF, 32'h0000ffe2);
        w32(`NST_OFS_LIM_LC, 32'h0000ffec);
        w32(`NST_OFS_LIM_LW, 32'h0000fff6);
        w32(`NST_OFS_LIM_UW, 32'h0000003c);
        w32(`NST_OFS_LIM_UC, 32'h00000050);
        w32(`NST_OFS_LIM_UF, 32'h00000064);
        r32(`NST_OFS_LIM_UC);
        chk(s, 32'h00000050);
    endtask
    task automatic t_zones;
        zs(16'h0050, 3'h5, 3'h5);
        zs(16'h004f, 3'h4, 3'h4);
        zs(16'h0064, 3'h6, 3'h6);
        zs(16'h003b, 3'h0, 3'h0);
        zs(16'hfff6, 3'h1, 3'h1);
        zs(16'hfff7, 3'h0, 3'h0);
        zs(16'hffec, 3'h2, 3'h2);
        zs(16'hffe2, 3'h3, 3'h3);
    endtask
    task automatic t_hyst;
        w32(`NST_OFS_HYST, 32'h2);
        r32(`NST_OFS_HYST);
        chk(s, 32'h2);
        zs(16'h0050, 3'h5, 3'h5);
        zs(16'h004f, 3'h4, 3'h5);
        zs(16'h004e, 3'h4, 3'h4);
        zs(16'hffec, 3'h2, 3'h2);
        zs(16'hffed, 3'h1, 3'h2);
        zs(16'hffee, 3'h1, 3'h1);
        w32(`NST_OFS_HYST, 32'h1);
    endtask
    task automatic t_manual;
        w32(`NST_OFS_CTRL, 32'h00003f03);
        w32(`NST_OFS_READ_REQ, 32'h1);
        r32(`NST_OFS_READING);
        chk(s, 32'h0000ffee);
        zs(16'h0050, 3'h5, 3'h5);
        zs(16'h003c, 3'h4, 3'h5);
        zs(16'hffec, 3'h2, 3'h2);
        zs(16'h0064, 3'h6, 3'h6);
        zs(16'h0000, 3'h0, 3'h6);
        w32(`NST_OFS_SET_OP, 32'h8);
        w32(`NST_OFS_READ_REQ, 32'h1);
        r32(`NST_OFS_STATUS);
        chk({31'h0, s[14]}, 32'h1);
        n = evn;
        zs(16'h0000, 3'h0, 3'h0);
        chk(32'(evn - n), 32'h1);
        chk({29'h0, ev_z}, 32'h0);
        w32(`NST_OFS_CTRL, `NST_CTRL_RESET);
    endtask
    task automatic t_events;
        n = evn;
        zs(16'h0050, 3'h5, 3'h5);
        chk(32'(evn - n), 32'h1);
        zs(16'h0050, 3'h5, 3'h5);
        chk(32'(evn - n), 32'h1);
        w32(`NST_OFS_PERIOD, 32'h8);
        rv <= 16'h0;
        repeat (40) @(posedge clk_i);
        chk(32'(evn - n), 32'h2);
        chk({29'h0, ev_z}, 32'h0);
        w32(`NST_OFS_PERIOD, 32'h00ffffff);
        for (int k = 1; k < 6; k++) begin
            w32(`NST_OFS_SET_OP, 32'((k % 5) << 2));
            r32(`NST_OFS_STATUS);
            chk({29'h0, s[10:8]}, 32'(k < 5 ? k : 4));
        end
        w32(`NST_OFS_SET_OP, 32'hc);
        for (int o = 1; o < 4; o++) begin
            w32(`NST_OFS_SET_OP, 32'hc | 32'(o % 3));
            repeat (3) @(posedge clk_i);
            chk({28'h0, ev_k, 1'b0, ev_o}, 32'h8 | 32'(o % 3));
        end
        zs(16'h0000, 3'h0, 3'h0);
        chk({31'h0, s[14]}, 32'h0);
        w32(`NST_OFS_INIT_REQ, 32'h1);
        r32(`NST_OFS_STATUS);
        chk({31'h0, s[14]}, 32'h1);
    endtask
    task automatic t_cmd;
        for (int h = 0; h < 2; h++) begin
            w32(`NST_OFS_HANDLE, h ? 32'hffff : 32'h0);
            w32(`NST_OFS_SET_OP, 32'h5);
            r32(`NST_OFS_STATUS);
            chk({s[23:16], 5'h0, s[10:8]}, 16'h8003);
        end
        w32(`NST_OFS_HANDLE, 32'h1);
        w32(`NST_OFS_SET_OP, 32'hb);
        r32(`NST_OFS_STATUS);
        chk({24'h0, s[23:16]}, 32'h2);
        w32(`NST_OFS_CTRL, 32'h00003f00);
        w32(`NST_OFS_SET_OP, 32'h8);
        r32(`NST_OFS_STATUS);
        chk({24'h0, s[23:16]}, 32'h2);
        w32(`NST_OFS_SET_OP, 32'h0);
        r32(`NST_OFS_STATUS);
        chk({24'h0, s[23:16]}, 32'h0);
        w32(`NST_OFS_CTRL, `NST_CTRL_RESET);
        zs(16'h0000, 3'h0, 3'h0);
        chk({31'h0, s[14]}, 32'h0);
        w32(`NST_OFS_SET_OP, 32'h1);
        zs(16'h0064, 3'h0, 3'h0);
        chk({30'h0, s[13:12]}, 32'h1);
        w32(`NST_OFS_RESTORE, 32'h1);
        r32(`NST_OFS_LIM_UC);
        chk(s, 32'h0);
    endtask
    // Watchdog against a hang.
    initial begin
        #750000;
        fails++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_zones();
        t_hyst();
        t_manual();
        t_events();
        t_cmd();
        finish_test();
    end
endmodule // nst_sensor_bench
`default_nettype wire
